// ---- rtl/cmc_top.v ----
`include "cmc_defs.vh"

module cmc_top (
	// Clock and reset
	input  wire                                   mclk,
	input  wire                                   reset_n,
	// Hub busses, 80 lines per hub, hub 0 in the low slice
	input  wire [`CMC_HUBS*`CMC_BUS_W-1:0]        hub_bus_in,
	output reg  [`CMC_HUBS*`CMC_BUS_W-1:0]        hub_bus_out,
	output reg  [`CMC_HUBS-1:0]                   hub_oe_n,
	// Hub handshake
	output reg  [`CMC_HUBS-1:0]                   hub_grant,
	output reg  [`CMC_HUBS-1:0]                   hub_rvalid,
	// Hub faults
	input  wire [`CMC_HUBS*`CMC_ADDR_W-1:0]       area_limit,
	output reg  [`CMC_HUBS-1:0]                   bounds_fault,
	output reg  [`CMC_HUBS-1:0]                   protect_irq,
	// Module straps
	input  wire [`CMC_MODS*`CMC_MODNUM_W-1:0]     module_num,
	input  wire [`CMC_MODS-1:0]                   interlace_en
);

	// ----------------------------------------
	// Hub request decode
	// ----------------------------------------
	reg  [`CMC_HUBS-1:0]               hub_req;
	reg  [`CMC_HUBS-1:0]               hub_oob;
	reg  [`CMC_ADDR_W-1:0]             a;
	reg  [`CMC_ADDR_W-1:0]             lim;
	integer                            h;

	// Bounds check against each hub's area limit, zero means unchecked
	always @* begin
		hub_req = {`CMC_HUBS{1'b0}};
		hub_oob = {`CMC_HUBS{1'b0}};
		a       = {`CMC_ADDR_W{1'b0}};
		lim     = {`CMC_ADDR_W{1'b0}};
		for (h = 0; h < `CMC_HUBS; h = h + 1) begin
			a   = hub_bus_in[h*`CMC_BUS_W +: `CMC_ADDR_W];
			lim = area_limit[h*`CMC_ADDR_W +: `CMC_ADDR_W];
			hub_oob[h] = hub_bus_in[h*`CMC_BUS_W + `CMC_F_REQ_BIT] &&
			             (lim != {`CMC_ADDR_W{1'b0}}) && (a >= lim);
			hub_req[h] = hub_bus_in[h*`CMC_BUS_W + `CMC_F_REQ_BIT] && !hub_oob[h];
		end
	end

	// ----------------------------------------
	// Per-module decode, priority and module
	// ----------------------------------------
	wire [`CMC_MODS-1:0]               m_busy;
	wire [`CMC_MODS-1:0]               m_grant;
	wire [`CMC_MODS-1:0]               m_rvalid;
	wire [`CMC_MODS-1:0]               m_pfault;
	wire [`CMC_MODS*3-1:0]             m_tag;
	wire [`CMC_MODS*`CMC_INFO_W-1:0]   m_rdata;

	genvar k;
	generate
		for (k = 0; k < `CMC_MODS; k = k + 1) begin : g_mod
			reg  [`CMC_HUBS-1:0]          hit;
			reg  [2:0]                    pick;
			reg                           any;
			reg  [`CMC_ADDR_W-1:0]        ad;
			reg  [`CMC_ADDR_W-1:0]        pick_ad;
			integer                       j;

			// Address swap, match and fixed priority with hub 0 first
			always @* begin
				hit     = {`CMC_HUBS{1'b0}};
				pick    = 3'h0;
				any     = 1'b0;
				ad      = {`CMC_ADDR_W{1'b0}};
				pick_ad = {`CMC_ADDR_W{1'b0}};
				for (j = `CMC_HUBS - 1; j >= 0; j = j - 1) begin
					ad = hub_bus_in[j*`CMC_BUS_W +: `CMC_ADDR_W];
					if (interlace_en[k]) begin
						ad[`CMC_ILV_BIT] = hub_bus_in[j*`CMC_BUS_W];
						ad[0]            = hub_bus_in[j*`CMC_BUS_W + `CMC_ILV_BIT];
					end
					hit[j] = hub_req[j] &&
					         (ad[`CMC_ADDR_W-1:`CMC_WORD_W] ==
					          module_num[k*`CMC_MODNUM_W +: `CMC_MODNUM_W]);
					if (hit[j]) begin
						pick    = j[2:0];
						pick_ad = ad;
						any     = 1'b1;
					end
				end
			end

			// Each module is its own sequencer, so all three can run at once
			cmc_module u_mod (
				.mclk               (mclk),
				.reset_n            (reset_n),
				.start              (any && !m_busy[k]),
				.word               (pick_ad[`CMC_WORD_W-1:0]),
				.wdata              (hub_bus_in[pick*`CMC_BUS_W + `CMC_F_INFO_LSB +: `CMC_INFO_W]),
				.op                 (hub_bus_in[pick*`CMC_BUS_W + `CMC_F_OP_LSB +: `CMC_F_OP_W]),
				.tag_in             (pick),
				.busy               (m_busy[k]),
				.grant              (m_grant[k]),
				.rvalid             (m_rvalid[k]),
				.prot_fault         (m_pfault[k]),
				.tag                (m_tag[k*3 +: 3]),
				.read_info_register (m_rdata[k*`CMC_INFO_W +: `CMC_INFO_W])
			);
		end
	endgenerate

	// ----------------------------------------
	// Crosspoint back to the hubs
	// ----------------------------------------
	reg  [`CMC_HUBS-1:0]                  next_rvalid;
	reg  [`CMC_HUBS-1:0]                  next_pirq;
	reg  [`CMC_HUBS*`CMC_BUS_W-1:0]       next_bus;
	integer                               m;
	integer                               g;

	// Route module events to the owning hub
	always @* begin
		hub_grant   = {`CMC_HUBS{1'b0}};
		next_rvalid = {`CMC_HUBS{1'b0}};
		next_pirq   = {`CMC_HUBS{1'b0}};
		next_bus    = hub_bus_out;
		for (m = 0; m < `CMC_MODS; m = m + 1) begin
			for (g = 0; g < `CMC_HUBS; g = g + 1) begin
				if (m_tag[m*3 +: 3] == g[2:0]) begin
					hub_grant[g] = hub_grant[g] | m_grant[m];
					next_pirq[g] = next_pirq[g] | m_pfault[m];
					if (m_rvalid[m]) begin
						next_rvalid[g] = 1'b1;
						next_bus[g*`CMC_BUS_W + `CMC_F_INFO_LSB +: `CMC_INFO_W] =
							m_rdata[m*`CMC_INFO_W +: `CMC_INFO_W];
					end
				end
			end
		end
	end

	// Registered hub outputs; drive the info lines one cycle per read
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hub_bus_out  <= {`CMC_HUBS*`CMC_BUS_W{1'b0}};
			hub_oe_n     <= {`CMC_HUBS{1'b1}};
			hub_rvalid   <= {`CMC_HUBS{1'b0}};
			protect_irq  <= {`CMC_HUBS{1'b0}};
			bounds_fault <= {`CMC_HUBS{1'b0}};
		end else begin
			hub_bus_out  <= next_bus;
			hub_oe_n     <= ~next_rvalid;
			hub_rvalid   <= next_rvalid;
			protect_irq  <= next_pirq;
			bounds_fault <= hub_oob;
		end
	end

endmodule // cmc_top

// ---- rtl/cmc_defs.vh ----
// Overview of operation
// - A store that hits a protected word is blocked and interrupts the requestor.
// - Requests whose address reaches the hub's area limit raise a bounds fault.
// - Each module holds 16384 words; one cabinet serves three modules.
// - Six request hubs, one per possible requesting unit.
// - Each hub carries 80 two-way lines for address and information.
// - Only the module whose number matches the module address accepts a request.
// - Any hub reaches any module; three modules may run at once.
// - Per module, a resolver connects only one of several contending hubs.
// - Hub zero has the highest priority; lower hub numbers win.
// - Each cycle reads destructively, then writes from the write register; a read writes the read data back.
// - Protected word and not overwrite: the read data is written back instead.
// - Twenty-bit address: low fourteen bits word, upper six bits module.
// - With interlace, address bits fourteen and zero are swapped before decoding.
// - Interlace is a static per-module jumper input.
// - A module under test must have its interlace jumper removed.
// - Overwrite ignores protection; silent protected write aborts without indication.
// - Grant 200 ns after start, data 200 ns later (hubs get data four cycles, 400 ns, after grant); modules run independently.
`ifndef CMC_DEFS_VH
`define CMC_DEFS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define CMC_HUBS          6
`define CMC_MODS          3
`define CMC_BUS_W         80
`define CMC_ADDR_W        20
`define CMC_WORD_W        14
`define CMC_MODNUM_W      6
`define CMC_INFO_W        52
`define CMC_DEPTH         16384
`define CMC_PROTECT_BIT   48
`define CMC_ILV_BIT       14

// ----------------------------------------
// Hub bus field positions
// ----------------------------------------
`define CMC_F_ADDR_LSB    0
`define CMC_F_INFO_LSB    20
`define CMC_F_REQ_BIT     72
`define CMC_F_OP_LSB      73
`define CMC_F_OP_W        2

// ----------------------------------------
// Operations
// ----------------------------------------
`define CMC_OP_READ       2'h0
`define CMC_OP_STORE      2'h1
`define CMC_OP_SILENT     2'h2
`define CMC_OP_OVERWRITE  2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CMC_CLK_NS        100
`define CMC_T_GRANT_NS    200
`define CMC_T_DATA_NS     200
`define CMC_T_CYCLE_NS    1200
`define CMC_GRANT_CYC     ((`CMC_T_GRANT_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_READ_CYC      (`CMC_GRANT_CYC + (`CMC_T_DATA_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_CYCLE_CYC     (`CMC_T_CYCLE_NS / `CMC_CLK_NS)
`define CMC_CNT_W         4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMC_RST_INFO      52'h0000000000000
`define CMC_RST_CNT       4'h0
`define CMC_RST_TAG       3'h0

`endif

// ---- rtl/cmc_module.v ----
`include "cmc_defs.vh"

module cmc_module (
	// Clock and reset
	input  wire                        mclk,
	input  wire                        reset_n,
	// Cycle start
	input  wire                        start,
	input  wire [`CMC_WORD_W-1:0]      word,
	input  wire [`CMC_INFO_W-1:0]      wdata,
	input  wire [1:0]                  op,
	input  wire [2:0]                  tag_in,
	// Status
	output wire                        busy,
	output wire                        grant,
	output reg                         rvalid,
	output reg                         prot_fault,
	output reg  [2:0]                  tag,
	output reg  [`CMC_INFO_W-1:0]      read_info_register
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_READ  = 2'h1;
	localparam [1:0] ST_WRITE = 2'h2;

	// Counter end points, cut to the counter width on purpose
	localparam integer          GRANT_I  = `CMC_GRANT_CYC;
	localparam integer          READ_I   = `CMC_READ_CYC;
	localparam integer          END_I    = `CMC_CYCLE_CYC - 1;
	localparam [`CMC_CNT_W-1:0] GRANT_AT = GRANT_I[`CMC_CNT_W-1:0];
	localparam [`CMC_CNT_W-1:0] READ_AT  = READ_I[`CMC_CNT_W-1:0];
	localparam [`CMC_CNT_W-1:0] END_AT   = END_I[`CMC_CNT_W-1:0];

	reg [1:0]               state;
	reg [`CMC_CNT_W-1:0]    cnt;
	reg [`CMC_WORD_W-1:0]   word_q;
	reg [1:0]               op_q;
	reg [`CMC_INFO_W-1:0]   write_info_register;
	reg                     keep_old;
	reg [`CMC_INFO_W-1:0]   core [0:`CMC_DEPTH-1];    // 16384 words

	// Busy across the whole read and write cycle
	assign busy  = (state != ST_IDLE);
	// Grant two cycles after start
	assign grant = (state == ST_READ) && (cnt == GRANT_AT);

	// ----------------------------------------
	// Cycle sequencer
	// ----------------------------------------
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state               <= ST_IDLE;
			cnt                 <= `CMC_RST_CNT;
			word_q              <= {`CMC_WORD_W{1'b0}};
			op_q                <= `CMC_OP_READ;
			tag                 <= `CMC_RST_TAG;
			write_info_register <= `CMC_RST_INFO;
			read_info_register  <= `CMC_RST_INFO;
			keep_old            <= 1'b0;
			rvalid              <= 1'b0;
			prot_fault          <= 1'b0;
		end else begin
			rvalid     <= 1'b0;
			prot_fault <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (start) begin
						state               <= ST_READ;
						cnt                 <= 4'h1;
						word_q              <= word;
						op_q                <= op;
						tag                 <= tag_in;
						write_info_register <= wdata;
					end
				end
				ST_READ: begin
					cnt <= cnt + 4'h1;
					if (cnt == READ_AT) begin
						// Destructive read into the read register
						read_info_register <= core[word_q];
						rvalid             <= 1'b1;
						keep_old           <= (op_q == `CMC_OP_READ) ||
						                      (core[word_q][`CMC_PROTECT_BIT] &&
						                       (op_q != `CMC_OP_OVERWRITE));
						prot_fault         <= core[word_q][`CMC_PROTECT_BIT] &&
						                      (op_q == `CMC_OP_STORE);
						state              <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					cnt <= cnt + 4'h1;
					if (cnt == END_AT) begin
						state <= ST_IDLE;
						cnt   <= `CMC_RST_CNT;
					end
				end
				default: begin
					state <= ST_IDLE;
					cnt   <= `CMC_RST_CNT;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Core write-back at cycle end
	// ----------------------------------------
	always @(posedge mclk) begin
		if ((state == ST_WRITE) && (cnt == END_AT)) begin
			core[word_q] <= keep_old ? read_info_register : write_info_register;
		end
	end

endmodule // cmc_module

// ---- sim/cmc_top_asserts.sv ----
// ----------------------------------------
// Port checker
// ----------------------------------------
module cmc_top_asserts (
	// Clock and reset
	input wire logic         mclk,
	input wire logic         reset_n,
	// Hub side
	input wire logic [479:0] hub_bus_in,
	input wire logic [5:0]   hub_oe_n,
	input wire logic [5:0]   hub_grant,
	input wire logic [5:0]   hub_rvalid,
	// Faults
	input wire logic [119:0] area_limit,
	input wire logic [5:0]   bounds_fault,
	input wire logic [5:0]   protect_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] req;
	logic [5:0] oob;

	// Request bits and out-of-area requests per hub
	always_comb begin
		for (int h = 0; h < 6; h++) begin
			req[h] = hub_bus_in[h*80+72];
			oob[h] = req[h] && (area_limit[h*20+:20] != 20'h00000)
				&& (hub_bus_in[h*80+:20] >= area_limit[h*20+:20]);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	AST_GRANT_PULSE: assert property (|hub_grant |=> (hub_grant & $past(hub_grant)) == 6'h00)
		else $error("grant held longer than one cycle");
	AST_RVALID_LAT: assert property (|hub_grant |-> ##4 hub_rvalid == $past(hub_grant, 4))
		else $error("read data not four cycles after grant");
	AST_OE_DRIVE: assert property (hub_oe_n == ~hub_rvalid)
		else $error("output enable not tied to read data cycle");
	AST_IRQ_SLOT: assert property ((protect_irq & ~hub_rvalid) == 6'h00)
		else $error("protect interrupt outside read data cycle");
	AST_GRANT_REQ: assert property (|hub_grant |-> (hub_grant & ~$past(req)) == 6'h00)
		else $error("grant without a request");
	AST_THREE_MAX: assert property ($countones(hub_grant) <= 3)
		else $error("more grants than modules");
	AST_BOUNDS: assert property (##1 bounds_fault == $past(oob))
		else $error("bounds fault wrong");
	AST_OOB_BLOCK: assert property ((hub_grant & bounds_fault) == 6'h00)
		else $error("out of area request granted");
endmodule // cmc_top_asserts

bind cmc_top cmc_top_asserts i_chk (
	.mclk         (mclk),
	.reset_n      (reset_n),
	.hub_bus_in   (hub_bus_in),
	.hub_oe_n     (hub_oe_n),
	.hub_grant    (hub_grant),
	.hub_rvalid   (hub_rvalid),
	.area_limit   (area_limit),
	.bounds_fault (bounds_fault),
	.protect_irq  (protect_irq)
);

// ---- sim/cmc_req_model.sv ----
// ----------------------------------------
// Requesting unit on one hub
// ----------------------------------------
module cmc_req_model (
	// Clock
	input  wire logic        mclk,
	// Hub lines
	output logic [79:0]      slice,
	input  wire logic        grant,
	input  wire logic        rvalid,
	input  wire logic [79:0] bus_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int cyc = 0;

	// Cycle count for grant stamps
	always @(posedge mclk) cyc <= cyc + 1;
	initial slice = 80'h0;

	// One request; holds lines until grant, then releases them inverted
	task automatic access(input logic [19:0] a, input logic [1:0] op, input logic [51:0] d,
			output int gc, output logic [51:0] q);
		int n;
		gc = -1;
		q = 52'h0;
		@(posedge mclk);
		#1 slice = {5'h00, op, 1'b1, d, a};
		for (n = 0; n < 30 && grant !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		if (grant === 1'b1)
			gc = cyc;
		@(posedge mclk);
		#1 slice = ~slice & ~(80'h1 << 72);
		for (n = 0; gc >= 0 && n < 8 && rvalid !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		q = bus_out[71:20];
	endtask
endmodule // cmc_req_model

// ---- sim/cmc_top_tb.sv ----
module cmc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic         mclk = 1'b0;
	logic         reset_n = 1'b0;
	logic [119:0] limit = 120'h0;
	wire  [479:0] bus_in;
	wire  [479:0] bus_out;
	wire  [5:0]   oe_n, grant, rvalid, bfault, irq;
	int           mismatches = 0, samples_checked = 0, irqs = 0, i0;
	logic [5:0]   bfs = 6'h00;
	int           gcs [6];
	logic [51:0]  qs [6];

	initial forever #50 mclk = ~mclk;

	cmc_top i_cmc_top (.mclk(mclk), .reset_n(reset_n), .hub_bus_in(bus_in), .hub_bus_out(bus_out),
		.hub_oe_n(oe_n), .hub_grant(grant), .hub_rvalid(rvalid), .area_limit(limit),
		.bounds_fault(bfault), .protect_irq(irq), .module_num(18'h02040), .interlace_en(3'h3));

	// One requesting unit per hub
	for (genvar h = 0; h < 6; h++) begin : g
		cmc_req_model m (.mclk(mclk), .slice(bus_in[h*80+:80]), .grant(grant[h]), .rvalid(rvalid[h]),
			.bus_out(bus_out[h*80+:80]));
	end

	// Interrupt and fault monitors
	always @(posedge mclk) begin
		irqs <= irqs + $countones(irq);
		bfs <= bfs | bfault;
	end

	task automatic acc(input int h, input logic [19:0] a, input logic [1:0] op, input logic [51:0] d);
		case (h)
			0: g[0].m.access(a, op, d, gcs[0], qs[0]);
			1: g[1].m.access(a, op, d, gcs[1], qs[1]);
			2: g[2].m.access(a, op, d, gcs[2], qs[2]);
			default: g[3].m.access(a, op, d, gcs[3], qs[3]);
		endcase
	endtask

	task automatic chk(input logic [51:0] e, input logic [51:0] v);
		samples_checked++;
		if (v !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, v);
		end
	endtask

	// Fresh word set by overwrite, store, two reads; plain module two alongside
	task automatic t_rw;
		acc(0, 20'h00010, 2'h3, 52'h0000000000000);
		acc(0, 20'h00010, 2'h1, 52'h0ABCDEF012345);
		acc(0, 20'h00010, 2'h0, 52'h0);
		chk(52'h0ABCDEF012345, qs[0]);
		acc(0, 20'h00010, 2'h0, 52'h0);
		chk(52'h0ABCDEF012345, qs[0]);
		fork
			acc(3, 20'h08010, 2'h3, 52'h00000000C0FFE);
			acc(0, 20'h00010, 2'h0, 52'h0);
		join
		chk(52'h1, 52'(gcs[3] < gcs[0]));
		chk(52'h0ABCDEF012345, qs[0]);
		acc(3, 20'h08010, 2'h0, 52'h0);
		chk(52'h00000000C0FFE, qs[3]);
	endtask

	// Protected word against store, silent write and overwrite
	task automatic t_prot;
		acc(1, 20'h00020, 2'h3, 52'h1000000000077);
		i0 = irqs;
		acc(1, 20'h00020, 2'h1, 52'h0000000000055);
		@(posedge mclk);
		#1 chk(52'h1, 52'(irqs - i0));
		acc(1, 20'h00020, 2'h2, 52'h0000000000099);
		acc(1, 20'h00020, 2'h0, 52'h0);
		chk(52'h1000000000077, qs[1]);
		chk(52'h1, 52'(irqs - i0));
		acc(1, 20'h00020, 2'h3, 52'h0000000000066);
		acc(1, 20'h00020, 2'h0, 52'h0);
		chk(52'h0000000000066, qs[1]);
	endtask

	// Interlaced neighbours run at once; same module is serialised by priority
	task automatic t_cross;
		repeat (12) @(posedge mclk);
		fork
			acc(1, 20'h00000, 2'h0, 52'h0);
			acc(2, 20'h00001, 2'h0, 52'h0);
		join
		chk(52'h0, 52'(gcs[2] - gcs[1]));
		fork
			acc(2, 20'h00040, 2'h0, 52'h0);
			acc(0, 20'h00040, 2'h0, 52'h0);
		join
		chk(52'hC, 52'(gcs[2] - gcs[0]));
	endtask

	// Area limit boundary and an absent module
	task automatic t_bound;
		@(posedge mclk);
		#1 limit[60+:20] = 20'h00100;
		acc(3, 20'h00100, 2'h0, 52'h0);
		chk(52'h1, 52'(gcs[3] < 0 && bfs[3]));
		acc(3, 20'h000FF, 2'h0, 52'h0);
		chk(52'h1, 52'(gcs[3] >= 0));
		@(posedge mclk);
		#1 limit[60+:20] = 20'h00000;
		acc(3, 20'h14000, 2'h0, 52'h0);
		chk(52'h1, 52'(gcs[3] < 0));
	endtask

	task automatic results;
		$display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge mclk);
		#1 reset_n = 1'b1;
		t_rw;
		t_prot;
		t_cross;
		t_bound;
		results;
	end

	// Watchdog
	initial begin
		#(100 * 3000);
		mismatches++;
		results;
	end
endmodule // cmc_top_tb
